//--- rspsc_consts.svh
`ifndef RSPSC_CONSTS_SVH
`define RSPSC_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RSPSC_PM_CTRL_ADDR 8'h00
`define RSPSC_PM_STAT_ADDR 8'h04
`define RSPSC_PULL_CTRL_ADDR 8'h08
`define RSPSC_DET_CTRL_ADDR 8'h0c
`define RSPSC_DEV_STAT_ADDR 8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSPSC_DEV_IDLE_BIT 0
`define RSPSC_COMP_SLEEP_BIT 1
`define RSPSC_DET_ID_PULL_BIT 0
`define RSPSC_DET_VBUS_CMP_BIT 1
`define RSPSC_DET_VBUS_SW_BIT 2
`define RSPSC_DET_A_SIDE_BIT 3
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RSPSC_PM_CTRL_RST 2'h0
`define RSPSC_PULL_CTRL_RST 8'h00
`define RSPSC_DET_CTRL_RST 4'h0
`define RSPSC_CORE_RST_CYCLES 5'h10
`define RSPSC_XTAL_KHZ 24000
`define RSPSC_EXT_CLK_KHZ 19200
`endif

//--- rspsc_pkg.sv
package rspsc_pkg;
  typedef enum logic [2:0] {
    RSPSC_ST_RESET = 3'b001,
    RSPSC_ST_IDLE = 3'b010,
    RSPSC_ST_NORMAL = 3'b100
  } rspsc_state_t;
  typedef enum logic {
    RSPSC_CLK_CRYSTAL = 1'b0,
    RSPSC_CLK_EXTERNAL = 1'b1
  } rspsc_clk_sel_t;
endpackage

//--- rspsc_sync2.sv
`timescale 1ns/1ps
// Two-flop synchroniser for an asynchronous level
module rspsc_sync2
  import rspsc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;
  logic sync_r;

  always_ff @(posedge core_clk_i)
  begin
    meta_r <= d_i;
    sync_r <= meta_r;
  end

  assign q_o = sync_r;
endmodule

//--- rspsc_ctrl.sv
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`include "rspsc_consts.svh"
module rspsc_ctrl
  import rspsc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ext_reset_n_i,
  input wire logic clock_source_strap_i,
  input wire logic host_if_strap_i,
  input wire logic wakeup_i,
  input wire logic id_level_i,
  input wire logic vbus_level_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic core_reset_o,
  output logic pins_func_en_o,
  output logic pins_bidir_oe_o,
  output logic pins_min_leak_o,
  output logic [7:0] pull_ctrl_o,
  output logic clock_source_sel_o,
  output logic host_if_sel_o,
  output logic host_if_reserved_o,
  output logic clocks_en_o,
  output logic phy_enable_o,
  output logic phy_suspend_o,
  output logic phy_refclk_en_o,
  output logic lp_vbus_cmp_en_o,
  output logic vbus_cmp_en_o,
  output logic session_end_det_en_o,
  output logic id_det_en_o,
  output logic otg_id_pull_enable_o,
  output logic vbus_switch_enable_o,
  output logic companion_sleep_o,
  output logic ready_irq_o,
  output logic [2:0] power_state_o
);
  // ----------------------------------------
  // Reset synchronisation
  // ----------------------------------------
  logic ext_rst_n_sync;
  logic clk_strap_sync;
  logic host_strap_sync;
  logic ext_rst_n_d_r;
  logic in_reset;
  logic [4:0] rst_cnt_r;
  logic core_reset_r;
  logic core_reset_d_r;

  rspsc_sync2 u_sync_rst
  (
    .core_clk_i(core_clk_i),
    .d_i(ext_reset_n_i),
    .q_o(ext_rst_n_sync)
  );

  rspsc_sync2 u_sync_clk_strap
  (
    .core_clk_i(core_clk_i),
    .d_i(clock_source_strap_i),
    .q_o(clk_strap_sync)
  );

  rspsc_sync2 u_sync_host_strap
  (
    .core_clk_i(core_clk_i),
    .d_i(host_if_strap_i),
    .q_o(host_strap_sync)
  );

  // Local reset, or external reset low once through the two-flop synchroniser, forces RESET at the next edge
  assign in_reset = reset_i | ~ext_rst_n_sync;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      ext_rst_n_d_r <= 1'b0;
    end
    else
    begin
      ext_rst_n_d_r <= ext_rst_n_sync;
    end
  end

  // ----------------------------------------
  // Core reset counter
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (in_reset)
    begin
      rst_cnt_r <= 5'h0;
      core_reset_r <= 1'b1;
    end
    else if (core_reset_r)
    begin
      rst_cnt_r <= rst_cnt_r + 5'h1;
      if (rst_cnt_r == `RSPSC_CORE_RST_CYCLES - 5'h1)
      begin
        core_reset_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      core_reset_d_r <= 1'b1;
    end
    else
    begin
      core_reset_d_r <= core_reset_r;
    end
  end

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  logic clk_sel_r;
  logic host_sel_r;

  // Straps follow the pins while reset is low, freeze on its rising edge
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      clk_sel_r <= RSPSC_CLK_CRYSTAL;
      host_sel_r <= 1'b0;
    end
    else if (!ext_rst_n_sync || !ext_rst_n_d_r)
    begin
      clk_sel_r <= clk_strap_sync;
      host_sel_r <= host_strap_sync;
    end
  end

  assign clock_source_sel_o = clk_sel_r;
  assign host_if_sel_o = host_sel_r;
  assign host_if_reserved_o = host_sel_r;

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  rspsc_state_t state_r;
  rspsc_state_t state_nxt;
  logic [1:0] pm_ctrl_r;
  logic dev_idle;
  logic comp_sleep;

  assign dev_idle = pm_ctrl_r[`RSPSC_DEV_IDLE_BIT];
  assign comp_sleep = pm_ctrl_r[`RSPSC_COMP_SLEEP_BIT];

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      RSPSC_ST_RESET:
      begin
        if (!core_reset_r)
        begin
          state_nxt = RSPSC_ST_NORMAL;
        end
      end
      RSPSC_ST_NORMAL:
      begin
        if (dev_idle)
        begin
          state_nxt = RSPSC_ST_IDLE;
        end
      end
      RSPSC_ST_IDLE:
      begin
        if (wakeup_i)
        begin
          state_nxt = RSPSC_ST_NORMAL;
        end
      end
      default:
      begin
        state_nxt = RSPSC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (in_reset)
    begin
      state_r <= RSPSC_ST_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  logic st_reset;
  logic st_idle;
  logic st_normal;

  assign st_reset = (state_r == RSPSC_ST_RESET);
  assign st_idle = (state_r == RSPSC_ST_IDLE);
  assign st_normal = (state_r == RSPSC_ST_NORMAL);
  assign power_state_o = state_r;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] pull_ctrl_r;
  logic [3:0] det_ctrl_r;
  logic acc_ok;
  logic [31:0] rdata_r;

  // Access only in NORMAL; IDLE refuses and keeps pull_ctrl_r and det_ctrl_r, but wake-up from IDLE clears pm_ctrl_r
  assign acc_ok = st_normal;

  always_ff @(posedge core_clk_i)
  begin
    if (in_reset)
    begin
      pm_ctrl_r <= `RSPSC_PM_CTRL_RST;
    end
    else if (st_idle && wakeup_i)
    begin
      pm_ctrl_r <= `RSPSC_PM_CTRL_RST;
    end
    else if (reg_wr_i && acc_ok && reg_addr_i == `RSPSC_PM_CTRL_ADDR)
    begin
      pm_ctrl_r <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (in_reset)
    begin
      pull_ctrl_r <= `RSPSC_PULL_CTRL_RST;
      det_ctrl_r <= `RSPSC_DET_CTRL_RST;
    end
    else if (reg_wr_i && acc_ok)
    begin
      if (reg_addr_i == `RSPSC_PULL_CTRL_ADDR)
      begin
        pull_ctrl_r <= reg_wdata_i[7:0];
      end
      if (reg_addr_i == `RSPSC_DET_CTRL_ADDR)
      begin
        det_ctrl_r <= reg_wdata_i[3:0];
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (in_reset)
    begin
      rdata_r <= 32'h0;
    end
    else if (reg_rd_i && acc_ok)
    begin
      unique case (reg_addr_i)
        `RSPSC_PM_CTRL_ADDR: rdata_r <= {30'h0, pm_ctrl_r};
        `RSPSC_PM_STAT_ADDR: rdata_r <= {26'h0, host_sel_r, clk_sel_r, 1'b0, state_r};
        `RSPSC_PULL_CTRL_ADDR: rdata_r <= {24'h0, pull_ctrl_r};
        `RSPSC_DET_CTRL_ADDR: rdata_r <= {28'h0, det_ctrl_r};
        `RSPSC_DEV_STAT_ADDR: rdata_r <= {30'h0, vbus_level_i, id_level_i};
        default: rdata_r <= 32'h0;
      endcase
    end
    else
    begin
      rdata_r <= 32'h0;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ----------------------------------------
  // Ready interrupt
  // ----------------------------------------
  logic ready_irq_r;

  always_ff @(posedge core_clk_i)
  begin
    if (in_reset)
    begin
      ready_irq_r <= 1'b0;
    end
    else
    begin
      ready_irq_r <= core_reset_d_r & ~core_reset_r;
    end
  end

  assign ready_irq_o = ready_irq_r;

  // ----------------------------------------
  // Pin, clock and PHY control
  // ----------------------------------------
  logic sleep_r;
  logic vbus_sw_r;

  always_ff @(posedge core_clk_i)
  begin
    if (in_reset)
    begin
      sleep_r <= 1'b0;
    end
    else
    begin
      sleep_r <= (state_nxt == RSPSC_ST_IDLE) && dev_idle && comp_sleep;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (in_reset)
    begin
      vbus_sw_r <= 1'b0;
    end
    else
    begin
      vbus_sw_r <= det_ctrl_r[`RSPSC_DET_VBUS_SW_BIT] && det_ctrl_r[`RSPSC_DET_A_SIDE_BIT]
        && !id_level_i;
    end
  end

  assign companion_sleep_o = sleep_r;
  assign vbus_switch_enable_o = vbus_sw_r & st_normal;
  assign core_reset_o = core_reset_r;
  assign pins_func_en_o = st_normal & ~core_reset_r;
  assign pins_bidir_oe_o = st_normal;
  assign pins_min_leak_o = st_idle;
  assign pull_ctrl_o = pull_ctrl_r;
  assign clocks_en_o = ~st_idle;
  assign phy_enable_o = ~st_idle;
  assign phy_suspend_o = st_idle;
  assign phy_refclk_en_o = ~st_idle;
  assign lp_vbus_cmp_en_o = st_idle;
  assign vbus_cmp_en_o = st_normal & det_ctrl_r[`RSPSC_DET_VBUS_CMP_BIT];
  assign session_end_det_en_o = st_normal;
  assign id_det_en_o = st_normal | st_idle;
  assign otg_id_pull_enable_o = st_normal & det_ctrl_r[`RSPSC_DET_ID_PULL_BIT];
endmodule

//--- rspsc_ctrl_asserts.sv
`timescale 1ns/1ps
module rspsc_ctrl_chk (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ext_reset_n_i,
  input wire logic wakeup_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic core_reset_o,
  input wire logic pins_func_en_o,
  input wire logic phy_refclk_en_o,
  input wire logic clocks_en_o,
  input wire logic phy_suspend_o,
  input wire logic lp_vbus_cmp_en_o,
  input wire logic companion_sleep_o,
  input wire logic ready_irq_o,
  input wire logic [2:0] power_state_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  property p_rst;
    power_state_o == 3'h1 |-> phy_refclk_en_o && !pins_func_en_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  property p_core;
    core_reset_o |-> power_state_o == 3'h1 && !pins_func_en_o;
  endproperty
  a_core: assert property (p_core) else $error("core reset outside RESET");
  property p_hold;
    $rose(ext_reset_n_i) |-> core_reset_o[*8] ##1 core_reset_o[*8] ##1 core_reset_o
      ##[1:5] !core_reset_o;
  endproperty
  a_hold: assert property (p_hold) else $error("core reset length");
  property p_irq;
    $fell(core_reset_o) |=> ready_irq_o ##1 !ready_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("ready pulse");
  property p_norm;
    power_state_o == 3'h4 |-> clocks_en_o && !phy_suspend_o;
  endproperty
  a_norm: assert property (p_norm) else $error("normal outputs");
  property p_idle;
    power_state_o == 3'h2 |-> !clocks_en_o && phy_suspend_o && lp_vbus_cmp_en_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle outputs");
  property p_sleep;
    companion_sleep_o |-> power_state_o == 3'h2;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outside idle");
  property p_wake;
    power_state_o == 3'h2 && wakeup_i && ext_reset_n_i |=> power_state_o == 3'h4;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up");
  property p_refuse;
    reg_rd_i && power_state_o != 3'h4 |=> reg_rdata_o == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("read not refused");
endmodule
bind rspsc_ctrl rspsc_ctrl_chk i_chk (
  .core_clk_i(core_clk_i),
  .reset_i(reset_i),
  .ext_reset_n_i(ext_reset_n_i),
  .wakeup_i(wakeup_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .core_reset_o(core_reset_o),
  .pins_func_en_o(pins_func_en_o),
  .phy_refclk_en_o(phy_refclk_en_o),
  .clocks_en_o(clocks_en_o),
  .phy_suspend_o(phy_suspend_o),
  .lp_vbus_cmp_en_o(lp_vbus_cmp_en_o),
  .companion_sleep_o(companion_sleep_o),
  .ready_irq_o(ready_irq_o),
  .power_state_o(power_state_o)
);

//--- rspsc_host_model.sv
`timescale 1ns/1ps
`include "rspsc_consts.svh"
module rspsc_host_model (
  input wire logic core_clk_i,
  input wire logic [31:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge core_clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge core_clk_i);
    rd_o <= 1'b0;
    #1 v = rdata_i;
  endtask
  task automatic detect(output logic [31:0] v);
    wr(`RSPSC_DET_CTRL_ADDR, 32'h3);
    rd(`RSPSC_DEV_STAT_ADDR, v);
  endtask
endmodule

//--- reset_strap_power_state_ctrl_bench.sv
`timescale 1ns/1ps
`include "rspsc_consts.svh"
module reset_strap_power_state_ctrl_bench;
  logic core_clk_i, reset_i, ext_reset_n_i, clock_source_strap_i, host_if_strap_i, wakeup_i;
  logic id_level_i, vbus_level_i, reg_wr_i, reg_rd_i, core_reset_o, pins_func_en_o;
  logic pins_bidir_oe_o, pins_min_leak_o, clock_source_sel_o, host_if_sel_o;
  logic host_if_reserved_o, clocks_en_o, phy_enable_o, phy_suspend_o, phy_refclk_en_o;
  logic lp_vbus_cmp_en_o, vbus_cmp_en_o, session_end_det_en_o, id_det_en_o;
  logic otg_id_pull_enable_o, vbus_switch_enable_o, companion_sleep_o, ready_irq_o;
  logic [7:0] reg_addr_i, pull_ctrl_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic [2:0] power_state_o;
  int fails, samples_checked;
  rspsc_ctrl i_dut (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .ext_reset_n_i(ext_reset_n_i),
    .clock_source_strap_i(clock_source_strap_i),
    .host_if_strap_i(host_if_strap_i),
    .wakeup_i(wakeup_i),
    .id_level_i(id_level_i),
    .vbus_level_i(vbus_level_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .core_reset_o(core_reset_o),
    .pins_func_en_o(pins_func_en_o),
    .pins_bidir_oe_o(pins_bidir_oe_o),
    .pins_min_leak_o(pins_min_leak_o),
    .pull_ctrl_o(pull_ctrl_o),
    .clock_source_sel_o(clock_source_sel_o),
    .host_if_sel_o(host_if_sel_o),
    .host_if_reserved_o(host_if_reserved_o),
    .clocks_en_o(clocks_en_o),
    .phy_enable_o(phy_enable_o),
    .phy_suspend_o(phy_suspend_o),
    .phy_refclk_en_o(phy_refclk_en_o),
    .lp_vbus_cmp_en_o(lp_vbus_cmp_en_o),
    .vbus_cmp_en_o(vbus_cmp_en_o),
    .session_end_det_en_o(session_end_det_en_o),
    .id_det_en_o(id_det_en_o),
    .otg_id_pull_enable_o(otg_id_pull_enable_o),
    .vbus_switch_enable_o(vbus_switch_enable_o),
    .companion_sleep_o(companion_sleep_o),
    .ready_irq_o(ready_irq_o),
    .power_state_o(power_state_o)
  );
  rspsc_host_model i_host (
    .core_clk_i(core_clk_i),
    .rdata_i(reg_rdata_o),
    .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i),
    .wr_o(reg_wr_i),
    .rd_o(reg_rd_i)
  );
  always #2.5 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic boot(input logic cs, input logic hs);
    int n;
    n = 0;
    @(posedge core_clk_i);
    ext_reset_n_i <= 1'b0;
    clock_source_strap_i <= cs;
    host_if_strap_i <= hs;
    repeat (20) @(posedge core_clk_i);
    chk(power_state_o, 3'h1);
    chk({pins_func_en_o, pins_bidir_oe_o, phy_refclk_en_o, phy_enable_o, clocks_en_o}, 5'h07);
    ext_reset_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    clock_source_strap_i <= ~cs;
    host_if_strap_i <= ~hs;
    while (power_state_o !== 3'h4 && n < 40)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk(n > 12, 1'b1);
    chk(ready_irq_o, 1'b1);
    chk({clocks_en_o, phy_suspend_o, core_reset_o}, 3'h4);
    @(negedge core_clk_i);
    chk(ready_irq_o, 1'b0);
    chk(clock_source_sel_o, cs);
    chk({host_if_sel_o, host_if_reserved_o}, {hs, hs});
    $display("boot done");
  endtask
  task automatic regs;
    i_host.wr(`RSPSC_PULL_CTRL_ADDR, 32'ha5);
    i_host.rd(`RSPSC_PULL_CTRL_ADDR, d);
    chk({d[7:0], pull_ctrl_o}, 16'ha5a5);
    i_host.rd(8'h20, d);
    i_host.rd(`RSPSC_PM_STAT_ADDR, d);
    chk(d[2:0], 3'h4);
    i_host.detect(d);
    chk(d[1:0], 2'h2);
    chk({otg_id_pull_enable_o, vbus_switch_enable_o}, 2'h2);
    i_host.wr(`RSPSC_DET_CTRL_ADDR, 32'hf);
    i_host.wr(`RSPSC_PM_CTRL_ADDR, 32'h2);
    repeat (2) @(negedge core_clk_i);
    chk({vbus_switch_enable_o, companion_sleep_o, power_state_o}, 5'h14);
    chk({phy_enable_o, session_end_det_en_o, vbus_cmp_en_o, id_det_en_o, pins_bidir_oe_o,
      pins_func_en_o, lp_vbus_cmp_en_o, pins_min_leak_o}, 8'hfc);
    $display("regs done");
  endtask
  task automatic idle(input logic s);
    i_host.wr(`RSPSC_PM_CTRL_ADDR, {30'h0, s, 1'b1});
    repeat (2) @(negedge core_clk_i);
    chk({power_state_o, companion_sleep_o}, {3'h2, s});
    chk({clocks_en_o, phy_suspend_o, lp_vbus_cmp_en_o}, 3'h3);
    chk({pins_min_leak_o, id_det_en_o}, 2'h3);
    chk({phy_enable_o, session_end_det_en_o, vbus_cmp_en_o, pins_func_en_o, pins_bidir_oe_o,
      phy_refclk_en_o}, 6'h00);
    i_host.wr(`RSPSC_PULL_CTRL_ADDR, 32'h3c);
    i_host.rd(`RSPSC_PULL_CTRL_ADDR, d);
    chk(d, 32'h0);
    @(posedge core_clk_i);
    wakeup_i <= 1'b1;
    @(posedge core_clk_i);
    wakeup_i <= 1'b0;
    @(negedge core_clk_i);
    chk({power_state_o, companion_sleep_o}, 4'h8);
    i_host.rd(`RSPSC_PULL_CTRL_ADDR, d);
    chk(d[7:0], 8'ha5);
    $display("idle done");
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    reset_i = 1'b1;
    ext_reset_n_i = 1'b0;
    clock_source_strap_i = 1'b0;
    host_if_strap_i = 1'b0;
    wakeup_i = 1'b0;
    id_level_i = 1'b0;
    vbus_level_i = 1'b1;
    fails = 0;
    samples_checked = 0;
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    boot(1'b0, 1'b0);
    regs;
    idle(1'b0);
    idle(1'b1);
    i_host.wr(`RSPSC_PM_CTRL_ADDR, 32'h1);
    repeat (2) @(negedge core_clk_i);
    boot(1'b1, 1'b1);
    chk({pull_ctrl_o, vbus_switch_enable_o}, 9'h0);
    end_sim;
  end
  initial
  begin
    #50000;
    fails++;
    end_sim;
  end
endmodule
